// *** acs_pkg.sv ***
// package for the conversion sequencer: field layout, register offsets, states, timing
// assumes one 250 MHz system clock shared by controller and converter ends
package acs_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESULT_W = 12;
  localparam logic [11:0] FULL_SCALE = 12'hFFF;
  localparam int CLKSEL_W = 3;
  localparam int DIV_W = 7;
  localparam logic [3:0] SAMPLE_LAST = 4'h3;
  localparam logic [3:0] CONV_LAST = 4'hF;
  // controller register offsets
  localparam logic [3:0] REG_CTRL0 = 4'h0;
  localparam logic [3:0] REG_CTRL1 = 4'h1;
  localparam logic [3:0] REG_CTRL2 = 4'h2;
  localparam logic [3:0] REG_INTCTL = 4'h3;
  localparam logic [3:0] REG_RESH = 4'h4;
  localparam logic [3:0] REG_RESL = 4'h5;
  // field positions
  localparam int CTRL0_POWER = 0;
  localparam int CTRL0_START = 1;
  localparam int CTRL0_BUSY = 2;
  localparam int CTRL0_CHAN = 4;
  localparam int CTRL1_CLKSEL = 0;
  localparam int CTRL1_SRC = 4;
  localparam int CTRL2_FORMAT = 0;
  localparam int CTRL2_REF = 2;
  localparam int INT_GLOBAL = 0;
  localparam int INT_CONV = 1;
  localparam int INT_FLAG = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_ARMED = 2'b01,
    ACS_SAMPLE = 2'b11,
    ACS_CONVERT = 2'b10
  } acs_state_t;
endpackage

// *** acs_if.sv ***
// interface joining the register-side controller to the converter sequencer
// assumes both ends run on the same clk
`timescale 1ns/1ps
interface acs_if;
  logic conv_power_enable;
  logic start;
  logic [3:0] external_channel_select;
  logic [2:0] conv_clock_select;
  logic [3:0] input_source_select;
  logic result_format_select;
  logic [1:0] reference_select;
  logic global_int_enable;
  logic conv_int_enable;
  logic int_flag_clear;
  logic conv_busy_flag;
  logic conv_int_request_flag;
  logic conv_irq;
  logic [7:0] result_high_reg;
  logic [7:0] result_low_reg;
  modport host (
    output conv_power_enable, start, external_channel_select, conv_clock_select, input_source_select,
    output result_format_select, reference_select, global_int_enable, conv_int_enable, int_flag_clear,
    input conv_busy_flag, conv_int_request_flag, conv_irq, result_high_reg, result_low_reg
  );
  modport dev (
    input conv_power_enable, start, external_channel_select, conv_clock_select, input_source_select,
    input result_format_select, reference_select, global_int_enable, conv_int_enable, int_flag_clear,
    output conv_busy_flag, conv_int_request_flag, conv_irq, result_high_reg, result_low_reg
  );
endinterface

// *** acs_clkdiv.sv ***
// converter clock divider: one-cycle tick at system clock / 2^sel
// assumes restart is a same-clock pulse that realigns the tick phase
`timescale 1ns/1ps
module acs_clkdiv (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic restart, // realign divider
  input wire logic [acs_pkg::CLKSEL_W-1:0] sel, // divide select
  output logic tick // one converter clock period elapsed
);
  logic [acs_pkg::DIV_W-1:0] cnt;
  wire [acs_pkg::DIV_W-1:0] mask = acs_pkg::DIV_W'((8'h01 << sel) - 8'h01);
  wire at_end = &(cnt | ~mask);

  assign tick = at_end & ~restart;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (restart || at_end) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

// *** acs_device.sv ***
// converter end: start-pulse decode, 4+12 clock sample/convert sequence, busy,
// request flag, result registers and analog input routing
// assumes analog_code is the front end's digitised level, steady across sampling
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module acs_device (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  acs_if.dev bus, // control from the controller end
  input wire logic [acs_pkg::RESULT_W-1:0] analog_code, // front-end level to convert
  output logic converter_powered, // analog core power
  output logic sample_active, // sample switch closed
  output logic ext_channel_enable, // external channel connected
  output logic [3:0] ext_channel, // external channel number
  output logic [2:0] internal_select, // internal signal code, 0 when none
  output logic ground_select, // converter input tied to ground
  output logic [1:0] reference_out // reference source to analog core
);
  acs_pkg::acs_state_t state, next_state;
  logic start_q;
  logic [3:0] cnt;
  logic busy;
  logic flag;
  logic [acs_pkg::RESULT_W-1:0] code_s1, code_s2, held, sar;

  wire power = bus.conv_power_enable;
  wire start_rise = bus.start & ~start_q;
  wire start_fall = ~bus.start & start_q;
  wire launch = power & (state == acs_pkg::ACS_ARMED) & start_fall;
  wire running = (state == acs_pkg::ACS_SAMPLE) | (state == acs_pkg::ACS_CONVERT);
  wire tick;
  wire sample_end = (state == acs_pkg::ACS_SAMPLE) & tick & (cnt == acs_pkg::SAMPLE_LAST);
  wire done = power & ~start_rise & (state == acs_pkg::ACS_CONVERT) & tick
    & (cnt == acs_pkg::CONV_LAST);

  // successive approximation: counts 4..15 try bits 11..0, msb first
  wire [3:0] bit_idx = acs_pkg::CONV_LAST - cnt;
  wire [acs_pkg::RESULT_W-1:0] trial = sar | (acs_pkg::RESULT_W'(1) << bit_idx);
  wire keep = (trial <= held);
  wire [acs_pkg::RESULT_W-1:0] next_sar = keep ? trial : sar;
  wire [7:0] next_high = bus.result_format_select ? {4'h0, next_sar[11:8]} : next_sar[11:4];
  wire [7:0] next_low = bus.result_format_select ? next_sar[7:0] : {next_sar[3:0], 4'h0};

  // aborted by power loss: busy drops without the request flag
  wire next_busy = power & (launch | (busy & ~done));
  wire next_flag = done | (flag & ~bus.int_flag_clear);

  wire [3:0] src = bus.input_source_select;
  wire src_ground = (src[3:2] == 2'b10);
  wire src_internal = ~src[3] & (src[1:0] != 2'b00);
  wire src_external = ~src_ground & ~src_internal;

  acs_clkdiv u_div (
    .clk(clk),
    .arst_n(arst_n),
    .restart(launch),
    .sel(bus.conv_clock_select),
    .tick(tick)
  );

  // the sequence advances on divider ticks alone, no software involvement
  always_comb begin
    next_state = state;
    case (state)
      acs_pkg::ACS_IDLE: begin
        if (start_rise) begin
          next_state = acs_pkg::ACS_ARMED;
        end
      end
      acs_pkg::ACS_ARMED: begin
        if (start_fall) begin
          next_state = acs_pkg::ACS_SAMPLE;
        end
      end
      acs_pkg::ACS_SAMPLE: begin
        if (start_rise) begin
          next_state = acs_pkg::ACS_ARMED;
        end else if (sample_end) begin
          next_state = acs_pkg::ACS_CONVERT;
        end
      end
      acs_pkg::ACS_CONVERT: begin
        if (start_rise) begin
          next_state = acs_pkg::ACS_ARMED;
        end else if (done) begin
          next_state = acs_pkg::ACS_IDLE;
        end
      end
      default: begin
        next_state = acs_pkg::ACS_IDLE;
      end
    endcase
    if (!power) begin
      next_state = acs_pkg::ACS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= acs_pkg::ACS_IDLE;
      start_q <= 1'b0;
      busy <= 1'b0;
      flag <= 1'b0;
    end else begin
      state <= next_state;
      start_q <= bus.start;
      busy <= next_busy;
      flag <= next_flag;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
    end else if (launch) begin
      cnt <= 4'h0;
    end else if (running && tick) begin
      cnt <= cnt + 4'h1;
    end
  end

  // the front-end word is treated as a quasi-static level, hence a plain two-stage sync
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_s1 <= '0;
      code_s2 <= '0;
    end else begin
      code_s1 <= analog_code;
      code_s2 <= code_s1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held <= '0;
    end else if (state == acs_pkg::ACS_SAMPLE && tick) begin
      held <= src_ground ? '0 : code_s2;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sar <= '0;
    end else if (launch) begin
      sar <= '0;
    end else if (state == acs_pkg::ACS_CONVERT && tick) begin
      sar <= next_sar;
    end
  end

  // results land on the same edge that drops busy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.result_high_reg <= 8'h00;
      bus.result_low_reg <= 8'h00;
    end else if (done) begin
      bus.result_high_reg <= next_high;
      bus.result_low_reg <= next_low;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.conv_irq <= 1'b0;
    end else begin
      bus.conv_irq <= next_flag & bus.conv_int_enable & bus.global_int_enable;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_powered <= 1'b0;
      sample_active <= 1'b0;
      ext_channel_enable <= 1'b0;
      ext_channel <= 4'h0;
      internal_select <= 3'h0;
      ground_select <= 1'b0;
      reference_out <= 2'h0;
    end else begin
      converter_powered <= power;
      sample_active <= (next_state == acs_pkg::ACS_SAMPLE);
      ext_channel_enable <= power & src_external;
      ext_channel <= bus.external_channel_select;
      internal_select <= src_internal ? src[2:0] : 3'h0;
      ground_select <= src_ground;
      reference_out <= bus.reference_select;
    end
  end

  assign bus.conv_busy_flag = busy;
  assign bus.conv_int_request_flag = flag;
endmodule

// *** acs_host.sv ***
// controller end: software-facing register file that drives the sequencer
// assumes a same-clock software port, read data valid the cycle after rd
`timescale 1ns/1ps
module acs_host #(
  parameter int SETTLE_NS = 1000 // power-up settling before start is passed on
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  acs_if.host bus, // link to the converter end
  input wire logic [3:0] addr, // register offset
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  output logic irq // converter interrupt to the core
);
  localparam int SETTLE_CYC = (SETTLE_NS + acs_pkg::CLK_PERIOD_NS - 1) / acs_pkg::CLK_PERIOD_NS;
  localparam int SET_W = $clog2(SETTLE_CYC + 1);

  logic [7:0] ctrl0, ctrl1, ctrl2;
  logic [1:0] intctl;
  logic [SET_W-1:0] settle;

  wire wr_ctrl0 = wr & (addr == acs_pkg::REG_CTRL0);
  wire wr_ctrl1 = wr & (addr == acs_pkg::REG_CTRL1);
  wire wr_ctrl2 = wr & (addr == acs_pkg::REG_CTRL2);
  wire wr_int = wr & (addr == acs_pkg::REG_INTCTL);
  wire power = ctrl0[acs_pkg::CTRL0_POWER];
  wire settled = (settle == SET_W'(SETTLE_CYC));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0 <= acs_pkg::REG_RESET;
      ctrl1 <= acs_pkg::REG_RESET;
      ctrl2 <= acs_pkg::REG_RESET;
      intctl <= 2'h0;
    end else begin
      if (wr_ctrl0) begin
        ctrl0 <= wdata;
      end
      if (wr_ctrl1) begin
        ctrl1 <= wdata;
      end
      if (wr_ctrl2) begin
        ctrl2 <= wdata;
      end
      if (wr_int) begin
        intctl <= wdata[1:0];
      end
    end
  end

  // count settling time from power enable; dropping power restarts it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle <= '0;
    end else if (!power) begin
      settle <= '0;
    end else if (!settled) begin
      settle <= settle + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.int_flag_clear <= 1'b0;
    end else begin
      bus.int_flag_clear <= wr_int & wdata[acs_pkg::INT_FLAG];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        acs_pkg::REG_CTRL0: rdata <= {ctrl0[7:3], bus.conv_busy_flag, ctrl0[1:0]};
        acs_pkg::REG_CTRL1: rdata <= ctrl1;
        acs_pkg::REG_CTRL2: rdata <= ctrl2;
        acs_pkg::REG_INTCTL: rdata <= {5'h00, bus.conv_int_request_flag, intctl};
        acs_pkg::REG_RESH: rdata <= bus.result_high_reg;
        acs_pkg::REG_RESL: rdata <= bus.result_low_reg;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // a start bit written before settling is held back from the converter until settling ends
  assign bus.start = ctrl0[acs_pkg::CTRL0_START] & settled;
  assign bus.conv_power_enable = power;
  assign bus.external_channel_select = ctrl0[acs_pkg::CTRL0_CHAN +: 4];
  assign bus.conv_clock_select = ctrl1[acs_pkg::CTRL1_CLKSEL +: 3];
  assign bus.input_source_select = ctrl1[acs_pkg::CTRL1_SRC +: 4];
  assign bus.result_format_select = ctrl2[acs_pkg::CTRL2_FORMAT];
  assign bus.reference_select = ctrl2[acs_pkg::CTRL2_REF +: 2];
  assign bus.global_int_enable = intctl[acs_pkg::INT_GLOBAL];
  assign bus.conv_int_enable = intctl[acs_pkg::INT_CONV];
  assign irq = bus.conv_irq;
endmodule

// *** acs_chk_sva.sv ***
// checker for the link between the controller end and the converter end
// assumes one clock; takes the link signals as plain inputs beside the interface
`timescale 1ns/1ps
module acs_chk (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic conv_power_enable, // power level
  input wire logic start, // start level
  input wire logic [2:0] conv_clock_select, // divide select
  input wire logic result_format_select, // result packing
  input wire logic global_int_enable, // global enable
  input wire logic conv_int_enable, // converter enable
  input wire logic int_flag_clear, // flag clear pulse
  input wire logic conv_busy_flag, // busy
  input wire logic conv_int_request_flag, // request flag
  input wire logic conv_irq, // interrupt level
  input wire logic [7:0] result_high_reg, // result high byte
  input wire logic [7:0] result_low_reg // result low byte
);
  logic start_q;
  logic armed;
  logic [11:0] busy_cnt;
  // mirrors the device's arming so the launch edge is known without its state
  wire launch = armed && start_q && !start && conv_power_enable;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'h0;
      armed <= 1'h0;
      busy_cnt <= 12'h000;
    end else begin
      start_q <= start;
      armed <= conv_power_enable && ((start && !start_q) || (armed && start));
      busy_cnt <= launch ? 12'h000 : busy_cnt + {11'h000, conv_busy_flag};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_done;
    $fell(conv_busy_flag) ##0 $past(conv_power_enable);
  endsequence
  sequence s_restart;
    conv_busy_flag && start && !start_q && conv_power_enable;
  endsequence
  chk_launch_busy: assert property (launch |=> conv_busy_flag)
    else $error("busy not raised after launch");
  chk_conv_length: assert property ($rose(conv_int_request_flag) |-> busy_cnt == (12'h010 << conv_clock_select))
    else $error("conversion length wrong");
  chk_done_flag: assert property (s_done |-> conv_int_request_flag)
    else $error("completion without request flag");
  chk_power_abort: assert property (!conv_power_enable |=> !conv_busy_flag && !$rose(conv_int_request_flag))
    else $error("power off did not abort");
  chk_irq_level: assert property (conv_irq == (conv_int_request_flag && $past(global_int_enable) && $past(conv_int_enable)))
    else $error("interrupt level wrong");
  chk_result_hold: assert property ($changed(result_high_reg) || $changed(result_low_reg) |-> $fell(conv_busy_flag))
    else $error("result changed outside completion");
  chk_restart_busy: assert property (s_restart |=> conv_busy_flag)
    else $error("busy dropped on restart");
  chk_flag_clear: assert property (int_flag_clear && !conv_busy_flag |=> !conv_int_request_flag)
    else $error("request flag not cleared");
  chk_format_pack: assert property (s_done |-> ($past(result_format_select) ? result_high_reg[7:4] : result_low_reg[3:0]) == 4'h0)
    else $error("result packing wrong");
endmodule

// *** adc_conversion_sequencer_bench.sv ***
// testbench: controller and converter ends joined by the interface, driven over the register port
// assumes SETTLE_NS shortened to 40 ns (10 cycles) so power-up waits stay brief
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
  logic clk, arst_n, wr, rd, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [11:0] analog_code;
  logic converter_powered, sample_active, ext_channel_enable, ground_select;
  logic [3:0] ext_channel;
  logic [2:0] internal_select;
  logic [1:0] reference_out;
  int miscompares = 0;
  int checked = 0;
  acs_if link();
  acs_host #(.SETTLE_NS(40)) acs_host_i (.clk(clk), .arst_n(arst_n), .bus(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  acs_device acs_device_i (.clk(clk), .arst_n(arst_n), .bus(link), .analog_code(analog_code),
    .converter_powered(converter_powered), .sample_active(sample_active), .ext_channel_enable(ext_channel_enable),
    .ext_channel(ext_channel), .internal_select(internal_select), .ground_select(ground_select),
    .reference_out(reference_out));
  acs_chk acs_chk_i (.clk(clk), .arst_n(arst_n), .conv_power_enable(link.conv_power_enable), .start(link.start),
    .conv_clock_select(link.conv_clock_select), .result_format_select(link.result_format_select),
    .global_int_enable(link.global_int_enable), .conv_int_enable(link.conv_int_enable),
    .int_flag_clear(link.int_flag_clear), .conv_busy_flag(link.conv_busy_flag),
    .conv_int_request_flag(link.conv_int_request_flag), .conv_irq(link.conv_irq),
    .result_high_reg(link.result_high_reg), .result_low_reg(link.result_low_reg));
  always #2 clk = ~clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  // counts busy cycles on the link; bounded so a stuck busy cannot hang the run
  // s counts the busy cycles in which the sample switch is closed
  task automatic wait_busy(output int n, output int s);
    n = 0;
    s = 0;
    for (int k = 0; k < 5000; k++) begin
      @(posedge clk);
      #1;
      if (link.conv_busy_flag === 1'h1) begin
        n++;
        if (sample_active === 1'h1) s++;
      end else if (n > 0) begin
        break;
      end
    end
  endtask
  task automatic conv(input logic [2:0] sel, input logic [3:0] src, input logic fmt, input logic [11:0] code);
    logic [7:0] h, l;
    logic [11:0] v;
    int n;
    int s;
    v = (src[3:2] == 2'h2) ? 12'h000 : code;
    analog_code <= code;
    wr_reg(acs_pkg::REG_CTRL1, {src, 1'h0, sel});
    wr_reg(acs_pkg::REG_CTRL2, {4'h0, 2'(sel), 1'h0, fmt});
    wr_reg(acs_pkg::REG_CTRL0, 8'h33);
    wr_reg(acs_pkg::REG_CTRL0, 8'h31);
    wait_busy(n, s);
    chk(16'(n), 16'h0010 << sel);
    chk(16'(s), 16'h0004 << sel);
    chk({14'h0000, reference_out}, {14'h0000, 2'(sel)});
    rd_reg(acs_pkg::REG_RESH, h);
    rd_reg(acs_pkg::REG_RESL, l);
    chk({h, l}, fmt ? {4'h0, v} : {v, 4'h0});
    rd_reg(acs_pkg::REG_INTCTL, h);
    chk({15'h0000, h[2]}, 16'h0001);
    chk({15'h0000, irq}, {15'h0000, &h[1:0]});
    wr_reg(acs_pkg::REG_INTCTL, {5'h00, 1'h1, h[1:0]});
    rd_reg(acs_pkg::REG_INTCTL, h);
    chk({15'h0000, h[2]}, 16'h0000);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    wr_reg(4'hF, 8'hFF);
    for (int a = 0; a < 6; a++) begin
      rd_reg(4'(a), d);
      chk({8'h00, d}, 16'h0000);
    end
    rd_reg(4'hF, d);
    chk({8'h00, d}, 16'h0000);
  endtask
  task automatic t_route();
    logic e, g;
    logic [2:0] i;
    wr_reg(acs_pkg::REG_CTRL0, 8'h31);
    for (int k = 0; k < 16; k++) begin
      wr_reg(acs_pkg::REG_CTRL1, {4'(k), 4'h0});
      repeat (2) @(posedge clk);
      #1;
      e = (k == 0) || (k == 4) || (k[3:2] == 2'h3);
      g = k[3:2] == 2'h2;
      i = (!k[3] && k[1:0] != 2'h0) ? k[2:0] : 3'h0;
      chk({11'h000, ext_channel_enable, ground_select, internal_select}, {11'h000, e, g, i});
      chk({11'h000, converter_powered, ext_channel}, {11'h000, 1'h1, 4'h3});
    end
    repeat (12) @(posedge clk);
  endtask
  task automatic t_abort();
    logic [7:0] h0, h;
    rd_reg(acs_pkg::REG_RESH, h0);
    analog_code <= 12'h777;
    wr_reg(acs_pkg::REG_CTRL1, 8'h02);
    wr_reg(acs_pkg::REG_CTRL0, 8'h33);
    wr_reg(acs_pkg::REG_CTRL0, 8'h31);
    repeat (20) @(posedge clk);
    rd_reg(acs_pkg::REG_CTRL0, h);
    chk({8'h00, h}, 16'h0035);
    wr_reg(acs_pkg::REG_CTRL0, 8'h30);
    wr_reg(acs_pkg::REG_CTRL0, 8'h32);
    wr_reg(acs_pkg::REG_CTRL0, 8'h30);
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, link.conv_busy_flag}, 16'h0000);
    rd_reg(acs_pkg::REG_INTCTL, h);
    chk({15'h0000, h[2]}, 16'h0000);
    rd_reg(acs_pkg::REG_RESH, h);
    chk({8'h00, h}, {8'h00, h0});
    wr_reg(acs_pkg::REG_CTRL0, 8'h31);
    repeat (20) @(posedge clk);
  endtask
  task automatic t_restart();
    logic [7:0] h, l;
    int n;
    int s;
    analog_code <= 12'h111;
    wr_reg(acs_pkg::REG_CTRL2, 8'h00);
    wr_reg(acs_pkg::REG_CTRL0, 8'h33);
    wr_reg(acs_pkg::REG_CTRL0, 8'h31);
    repeat (20) @(posedge clk);
    analog_code <= 12'h9E1;
    wr_reg(acs_pkg::REG_CTRL0, 8'h33);
    wr_reg(acs_pkg::REG_CTRL0, 8'h31);
    // the new rise has been seen by now, so a busy dropped on restart shows here
    #1 chk({15'h0000, link.conv_busy_flag}, 16'h0001);
    wait_busy(n, s);
    chk(16'(n), 16'h0040);
    chk(16'(s), 16'h0010);
    rd_reg(acs_pkg::REG_RESH, h);
    rd_reg(acs_pkg::REG_RESL, l);
    chk({h, l}, 16'h9E10);
    wr_reg(acs_pkg::REG_INTCTL, 8'h04);
  endtask
  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    analog_code = 12'h000;
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    t_reset();
    t_route();
    // at 250 MHz only select 7 keeps the converter clock in range; the others exercise the divider
    for (int s = 0; s < 8; s++) conv(3'(s), 4'h0, s[0], (s == 7) ? 12'hFFF : 12'h5A3 + 12'(s));
    wr_reg(acs_pkg::REG_INTCTL, 8'h03);
    conv(3'h1, 4'hC, 1'h0, 12'h123);
    conv(3'h0, 4'h8, 1'h1, 12'hABC);
    conv(3'h0, 4'h5, 1'h0, 12'h456);
    wr_reg(acs_pkg::REG_INTCTL, 8'h00);
    t_abort();
    t_restart();
    wr_reg(acs_pkg::REG_CTRL0, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, converter_powered}, 16'h0000);
    give_verdict();
  end
  // whole sequence needs roughly 4700 cycles; the limit leaves wide margin
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule
